// [hw/maclue_pkg.sv]
// maclue_pkg: shared constants, types and field layouts for the lookup engine
// assumes one switch core clock; seven ports numbered 0..6 map to mask bits 0..6
package maclue_pkg;
  localparam int NPORT = 7;
  localparam int WAYS = 4;
  localparam int IDX_W = 10;
  localparam int BUCKETS = 1024;
  localparam int STAT_N = 16;
  localparam int RSV_N = 8;
  localparam int FID_W = 7;
  localparam int TS_W = 12;
  localparam int CLK_HZ = 50000000;
  localparam int AGE_TICK_MS = 1;
  localparam int AGE_TICK_CYC = CLK_HZ / 1000 * AGE_TICK_MS;
  localparam logic [TS_W-1:0] AGE_DEF_SEC = 12'h12C;
  localparam logic [TS_W-1:0] AGE_MIN_SEC = 12'h001;
  localparam logic [TS_W-1:0] AGE_MAX_SEC = 12'h708;
  localparam logic [10:0] MIN_FRAME = 11'h040;
  localparam logic [10:0] MAX_FRAME_DEF = 11'h5EE;
  localparam logic [10:0] MAX_FRAME_LONG = 11'h7D0;
  localparam logic [1:0] HASH_DEF = 2'h1;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [NPORT-1:0] MASK_ALL = 7'h7F;
  localparam logic [NPORT-1:0] RSV_DEF [RSV_N] = '{7'h40, 7'h00, 7'h40, 7'h7F, 7'h3F, 7'h3F, 7'h40, 7'h3F};

  typedef struct packed {
    logic valid;
    logic stat;
    logic [47:0] mac;
    logic [FID_W-1:0] filter_group_id;
    logic [NPORT-1:0] ports;
    logic [TS_W-1:0] ts;
  } maclue_entry_t;

  typedef struct packed {
    logic [47:0] da;
    logic [47:0] sa;
    logic [FID_W-1:0] filter_group_id;
    logic [2:0] src_port;
    logic [10:0] len;
    logic frame_err;
    logic pause;
    logic mgmt;
    logic fid_member;
    logic [NPORT-1:0] acl_mask;
    logic acl_override;
  } maclue_frame_t;

  typedef enum logic [1:0] {
    MACLUE_SW_NONE = 2'b00,
    MACLUE_SW_ALU = 2'b01,
    MACLUE_SW_STAT = 2'b10,
    MACLUE_SW_RSV = 2'b11
  } maclue_sw_t;
endpackage

// [hw/maclue_engine.sv]
// maclue_engine: destination lookup, learning, migration, aging and mask forming
// assumes frame descriptors arrive from the receive MACs on the core clock
`timescale 1ns/1ps
// What this block does
// - address table is 4-way set-associative, 1024 buckets, dynamic and static entries
// - address plus group id reduced to 10-bit index; four ways compared at once
// - group id used in hash with VLAN on, zero when off
// - select 01: CRC-CCITT of address, low ten bits plus group id
// - select 10: XOR of three address slices, low ten bits plus group id
// - select 00 or 11: low ten address bits plus group id
// - sixteen-entry static table, software written, searched alongside
// - eight reserved multicast groups, off after reset, masks rewritable
// - groups 0,2,6 highest port; group 1 drop; group 3 all ports
// - groups 4,5,7 flood all but the highest port
// - single hit gives ports; static result wins over dynamic
// - learn only absent, clean, legal-size, unicast sources, group members only when VLAN on
// - learned entry keeps port and stamp; evict oldest dynamic, never static
// - bucket fully static: skip learning, capture index, flag event unless software writes the address table that cycle
// - known dynamic source from new port on clean frame updates stored port
// - seen source refreshes stamp; background scan removes stale dynamics
// - aging period default 300 s, 1 s to 30 min, switchable off
// - stage-one mask from lookups, then port VLAN stage
// - ACL result may override, giving the final mask
// - errored or illegal-size frames never forwarded
// - pause, management and local frames dropped
// - per-ingress allowed-egress mask applied unless ACL override, all allowed at reset
// - frames under 64 bytes or over programmed maximum are illegal size
module maclue_engine (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic FRAME_VALID_I,
  input wire maclue_pkg::maclue_frame_t FRAME_I,
  input wire logic VLAN_EN_I,
  input wire logic [1:0] HASH_SEL_I,
  input wire logic LONG_FRAME_I,
  input wire logic AGE_EN_I,
  input wire logic [11:0] AGE_SEC_I,
  input wire logic RSV_EN_I,
  input wire logic [6:0] PORT_ALLOW_I [7],
  input wire logic SW_WR_I,
  input wire maclue_pkg::maclue_sw_t SW_SEL_I,
  input wire logic [9:0] SW_IDX_I,
  input wire logic [1:0] SW_WAY_I,
  input wire maclue_pkg::maclue_entry_t SW_ENTRY_I,
  output logic RESULT_VALID_O,
  output logic [6:0] STAGE_ONE_PORT_MASK_O,
  output logic [6:0] FINAL_PORT_MASK_O,
  output logic LEARN_FAIL_O,
  output logic [9:0] LEARN_FAIL_IDX_O
);
  import maclue_pkg::*;

  maclue_entry_t table_r [BUCKETS][WAYS];
  maclue_entry_t stat_r [STAT_N];
  logic [NPORT-1:0] rsv_r [RSV_N];
  logic [TS_W-1:0] now_r;
  logic [$clog2(AGE_TICK_CYC)-1:0] tick_cnt_r;
  logic [9:0] ms_cnt_r;
  logic [IDX_W-1:0] scan_r;
  logic rsv_on_r;

  function automatic logic [IDX_W-1:0] hash_idx(input logic [47:0] mac, input logic [FID_W-1:0] filter_group_id,
                                                 input logic [1:0] sel);
    logic [15:0] crc;
    logic [15:0] fold;
    logic fb;
    crc = CRC_INIT;
    fold = mac[47:32] ^ mac[31:16] ^ mac[15:0];
    for (int i = 47; i >= 0; i--) begin
      fb = crc[15] ^ mac[i];
      crc = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    unique case (sel)
      2'b01: hash_idx = crc[9:0] + {3'h0, filter_group_id};
      2'b10: hash_idx = fold[9:0] + {3'h0, filter_group_id};
      default: hash_idx = mac[9:0] + {3'h0, filter_group_id};
    endcase
  endfunction

  // aging clock: one-second stamp counter
  logic sec_tick;
  assign sec_tick = (tick_cnt_r == AGE_TICK_CYC[$clog2(AGE_TICK_CYC)-1:0] - 1'b1) && (ms_cnt_r == 10'h3E7);
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      tick_cnt_r <= '0;
      ms_cnt_r <= '0;
      now_r <= '0;
    end else if (tick_cnt_r == AGE_TICK_CYC[$clog2(AGE_TICK_CYC)-1:0] - 1'b1) begin
      tick_cnt_r <= '0;
      ms_cnt_r <= (ms_cnt_r == 10'h3E7) ? 10'h000 : ms_cnt_r + 10'h001;
      if (sec_tick) begin
        now_r <= now_r + 12'h001;
      end
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  // lookup, combinational against the current table
  logic [FID_W-1:0] fid_eff;
  logic [IDX_W-1:0] da_idx;
  logic [IDX_W-1:0] sa_idx;
  logic [WAYS-1:0] da_hit;
  logic [WAYS-1:0] sa_hit;
  logic [STAT_N-1:0] st_hit;
  assign fid_eff = VLAN_EN_I ? FRAME_I.filter_group_id : '0;
  assign da_idx = hash_idx(FRAME_I.da, fid_eff, HASH_SEL_I);
  assign sa_idx = hash_idx(FRAME_I.sa, fid_eff, HASH_SEL_I);

  genvar g;
  generate
    for (g = 0; g < WAYS; g++) begin : g_way
      assign da_hit[g] = table_r[da_idx][g].valid && table_r[da_idx][g].mac == FRAME_I.da
                         && table_r[da_idx][g].filter_group_id == fid_eff;
      assign sa_hit[g] = table_r[sa_idx][g].valid && table_r[sa_idx][g].mac == FRAME_I.sa
                         && table_r[sa_idx][g].filter_group_id == fid_eff;
    end
    for (g = 0; g < STAT_N; g++) begin : g_stat
      assign st_hit[g] = stat_r[g].valid && stat_r[g].mac == FRAME_I.da;
    end
  endgenerate

  logic is_rsv;
  logic [2:0] rsv_grp;
  logic [NPORT-1:0] alu_ports;
  logic alu_static;
  logic [NPORT-1:0] st_ports;
  logic [NPORT-1:0] s1_mask;
  logic [NPORT-1:0] src_bit;
  logic [10:0] max_len;
  logic size_ok;
  logic clean;
  logic drop;
  logic [NPORT-1:0] fin_mask;

  assign is_rsv = FRAME_I.da[47:8] == 40'h0180C20000 && FRAME_I.da[7:0] <= 8'h2F;
  always_comb begin
    unique case (FRAME_I.da[7:0])
      8'h00: rsv_grp = 3'd0;
      8'h01: rsv_grp = 3'd1;
      8'h03: rsv_grp = 3'd2;
      8'h10: rsv_grp = 3'd3;
      8'h20: rsv_grp = 3'd4;
      8'h21: rsv_grp = 3'd5;
      default: rsv_grp = (FRAME_I.da[7:0] < 8'h10) ? 3'd6 : 3'd7;
    endcase
  end

  always_comb begin
    alu_ports = '0;
    alu_static = 1'b0;
    st_ports = '0;
    for (int w = 0; w < WAYS; w++) begin
      if (da_hit[w]) begin
        alu_ports = table_r[da_idx][w].ports;
        alu_static = table_r[da_idx][w].stat;
      end
    end
    for (int s = 0; s < STAT_N; s++) begin
      if (st_hit[s]) begin
        st_ports = stat_r[s].ports;
      end
    end
  end

  always_comb begin
    if (rsv_on_r && is_rsv) begin
      s1_mask = rsv_r[rsv_grp];
    end else if (|st_hit) begin
      s1_mask = st_ports;
    end else if (|da_hit) begin
      s1_mask = alu_ports;
    end else begin
      s1_mask = MASK_ALL;
    end
  end

  assign src_bit = 7'h01 << FRAME_I.src_port[2:0];
  assign max_len = LONG_FRAME_I ? MAX_FRAME_LONG : MAX_FRAME_DEF;
  assign size_ok = FRAME_I.len >= MIN_FRAME && FRAME_I.len <= max_len;
  assign clean = !FRAME_I.frame_err && size_ok;
  assign drop = !clean || FRAME_I.pause || FRAME_I.mgmt
                || ((|da_hit || |st_hit) && s1_mask == src_bit);
  always_comb begin
    fin_mask = s1_mask & PORT_ALLOW_I[FRAME_I.src_port] & ~src_bit;
    if (FRAME_I.acl_override) begin
      fin_mask = FRAME_I.acl_mask;
    end
    if (drop) begin
      fin_mask = '0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      RESULT_VALID_O <= 1'b0;
      STAGE_ONE_PORT_MASK_O <= '0;
      FINAL_PORT_MASK_O <= '0;
    end else begin
      RESULT_VALID_O <= FRAME_VALID_I;
      STAGE_ONE_PORT_MASK_O <= FRAME_VALID_I ? s1_mask : '0;
      FINAL_PORT_MASK_O <= FRAME_VALID_I ? fin_mask : '0;
    end
  end

  // learning decision
  logic learn_ok;
  logic [WAYS-1:0] free_way;
  logic [1:0] victim;
  logic have_victim;
  logic [TS_W-1:0] oldest_age;
  logic [1:0] hit_way;
  assign learn_ok = FRAME_VALID_I && clean && !FRAME_I.sa[40] && (!VLAN_EN_I || FRAME_I.fid_member);
  always_comb begin
    victim = 2'd0;
    have_victim = 1'b0;
    oldest_age = '0;
    hit_way = 2'd0;
    for (int w = WAYS - 1; w >= 0; w--) begin
      free_way[w] = !table_r[sa_idx][w].valid;
      if (sa_hit[w]) begin
        hit_way = 2'(w);
      end
    end
    // evict only from a full bucket; a free way always wins over the oldest dynamic
    for (int w = 0; w < WAYS; w++) begin
      if (!(|free_way) && !table_r[sa_idx][w].stat
          && (!have_victim || (now_r - table_r[sa_idx][w].ts) > oldest_age)) begin
        victim = 2'(w);
        have_victim = 1'b1;
        oldest_age = now_r - table_r[sa_idx][w].ts;
      end
    end
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (free_way[w]) begin
        victim = 2'(w);
        have_victim = 1'b1;
      end
    end
  end

  logic age_hit;
  logic [WAYS-1:0] age_stale;
  generate
    for (g = 0; g < WAYS; g++) begin : g_age
      assign age_stale[g] = table_r[scan_r][g].valid && !table_r[scan_r][g].stat
                            && (now_r - table_r[scan_r][g].ts) >= AGE_SEC_I;
    end
  endgenerate
  assign age_hit = AGE_EN_I && |age_stale;

  // single writer, fixed priority: software, then frame, then aging
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      for (int b = 0; b < BUCKETS; b++) begin
        for (int w = 0; w < WAYS; w++) begin
          table_r[b][w].valid <= 1'b0;
        end
      end
    end else if (SW_WR_I && SW_SEL_I == MACLUE_SW_ALU) begin
      table_r[SW_IDX_I][SW_WAY_I] <= SW_ENTRY_I;
    end else if (learn_ok && |sa_hit) begin
      if (!table_r[sa_idx][hit_way].stat) begin
        table_r[sa_idx][hit_way].ts <= now_r;
        table_r[sa_idx][hit_way].ports <= src_bit;
      end
    end else if (learn_ok && have_victim) begin
      table_r[sa_idx][victim] <= '{valid: 1'b1, stat: 1'b0, mac: FRAME_I.sa, filter_group_id: fid_eff,
                                  ports: src_bit, ts: now_r};
    end else if (age_hit && !FRAME_VALID_I) begin
      for (int w = 0; w < WAYS; w++) begin
        if (age_stale[w]) begin
          table_r[scan_r][w].valid <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      scan_r <= '0;
    end else if (!FRAME_VALID_I && !(SW_WR_I && SW_SEL_I == MACLUE_SW_ALU)) begin
      scan_r <= scan_r + 10'h001;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      for (int s = 0; s < STAT_N; s++) begin
        stat_r[s].valid <= 1'b0;
      end
    end else if (SW_WR_I && SW_SEL_I == MACLUE_SW_STAT) begin
      stat_r[SW_IDX_I[3:0]] <= SW_ENTRY_I;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      for (int r = 0; r < RSV_N; r++) begin
        rsv_r[r] <= RSV_DEF[r];
      end
    end else if (SW_WR_I && SW_SEL_I == MACLUE_SW_RSV) begin
      rsv_r[SW_IDX_I[2:0]] <= SW_ENTRY_I.ports;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rsv_on_r <= 1'b0;
    end else begin
      rsv_on_r <= RSV_EN_I;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      LEARN_FAIL_O <= 1'b0;
      LEARN_FAIL_IDX_O <= '0;
    end else begin
      LEARN_FAIL_O <= learn_ok && !(|sa_hit) && !have_victim && !(SW_WR_I && SW_SEL_I == MACLUE_SW_ALU);
      if (learn_ok && !(|sa_hit) && !have_victim) begin
        LEARN_FAIL_IDX_O <= sa_idx;
      end
    end
  end

  pause_drop_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    FRAME_VALID_I && FRAME_I.pause |=> RESULT_VALID_O && FINAL_PORT_MASK_O == 7'h00)
    else $error("pause frame forwarded");
  err_drop_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    FRAME_VALID_I && !clean |=> FINAL_PORT_MASK_O == 7'h00)
    else $error("errored frame forwarded");
  allow_mask_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    FRAME_VALID_I && !FRAME_I.acl_override |=>
    (FINAL_PORT_MASK_O & ~$past(PORT_ALLOW_I[FRAME_I.src_port])) == 7'h00)
    else $error("egress outside allowed mask");
  acl_win_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    FRAME_VALID_I && FRAME_I.acl_override && !drop |=> FINAL_PORT_MASK_O == $past(FRAME_I.acl_mask))
    else $error("acl override ignored");
  static_wins_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    FRAME_VALID_I && |st_hit && !(rsv_on_r && is_rsv) |=> STAGE_ONE_PORT_MASK_O == $past(st_ports))
    else $error("static result not preferred");
  rsv_off_a: assert property (@(posedge MCLK_I) RESET_I |=> !rsv_on_r)
    else $error("reserved table enabled after reset");
  fail_idx_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    LEARN_FAIL_O |-> LEARN_FAIL_IDX_O == $past(sa_idx))
    else $error("learn fail index wrong");
  short_frame_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    FRAME_VALID_I && FRAME_I.len < MIN_FRAME |-> !learn_ok)
    else $error("short frame learned");
endmodule

// [tb/maclue_rx_model.sv]
// maclue_rx_model: receive MAC side, hands the engine one frame descriptor per call
// assumes callers sit on the core clock; drives only on rising edges
`timescale 1ns/1ps
module maclue_rx_model (
  input wire logic clk_i,
  output logic frame_valid_o,
  output maclue_pkg::maclue_frame_t frame_o
);
  import maclue_pkg::*;
  initial begin
    frame_valid_o = 1'b0;
    frame_o = '0;
  end
  task automatic send(input maclue_frame_t f);
    @(posedge clk_i);
    frame_valid_o <= 1'b1;
    frame_o <= f;
    @(posedge clk_i);
    frame_valid_o <= 1'b0;
    // descriptor no longer valid: show junk, never the old value
    frame_o <= ~f;
  endtask
endmodule

// [tb/tb_top.sv]
// tb_top: self-checking bench for the lookup engine, random addresses with fixed seed
// assumes seven ports, one core clock and software writes straight on ports
`timescale 1ns/1ps
module tb_top;
  import maclue_pkg::*;
  logic MCLK_I = 1'b0;
  logic RESET_I = 1'b1;
  logic frame_valid;
  maclue_frame_t frame;
  logic long_frame = 1'b0;
  logic rsv_en = 1'b0;
  logic vlan_en = 1'b0;
  logic age_en = 1'b1;
  logic sw_wr = 1'b0;
  logic [1:0] hash_sel = HASH_DEF;
  logic [6:0] allow [7] = '{default: 7'h7F};
  maclue_sw_t sw_sel = MACLUE_SW_NONE;
  logic [9:0] sw_idx = 10'h000;
  logic [1:0] sw_way = 2'h0;
  maclue_entry_t sw_entry = '0;
  logic res_v;
  logic lfail;
  logic [6:0] m1;
  logic [6:0] m2;
  logic [9:0] lidx;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 21;
  int lens [7] = '{63, 64, 1518, 1519, 1519, 2000, 2001};
  logic [7:0] sfx [8] = '{8'h00, 8'h01, 8'h03, 8'h10, 8'h20, 8'h21, 8'h02, 8'h11};
  logic [6:0] rsv_exp [8] = '{7'h40, 7'h00, 7'h40, 7'h7F, 7'h3F, 7'h3F, 7'h40, 7'h3F};

  always #10 MCLK_I = ~MCLK_I;

  maclue_rx_model maclue_rx_model_i (.clk_i(MCLK_I), .frame_valid_o(frame_valid), .frame_o(frame));
  maclue_engine maclue_engine_i (.MCLK_I(MCLK_I), .RESET_I(RESET_I), .FRAME_VALID_I(frame_valid),
    .FRAME_I(frame), .VLAN_EN_I(vlan_en), .HASH_SEL_I(hash_sel), .LONG_FRAME_I(long_frame),
    .AGE_EN_I(age_en), .AGE_SEC_I(AGE_DEF_SEC), .RSV_EN_I(rsv_en), .PORT_ALLOW_I(allow),
    .SW_WR_I(sw_wr), .SW_SEL_I(sw_sel), .SW_IDX_I(sw_idx), .SW_WAY_I(sw_way), .SW_ENTRY_I(sw_entry),
    .RESULT_VALID_O(res_v), .STAGE_ONE_PORT_MASK_O(m1), .FINAL_PORT_MASK_O(m2),
    .LEARN_FAIL_O(lfail), .LEARN_FAIL_IDX_O(lidx));

  function automatic logic [15:0] crc(input logic [47:0] m);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 47; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  // hash part of the index only; callers add the group id when VLAN is on
  function automatic logic [9:0] idx_of(input logic [1:0] s, input logic [47:0] m);
    logic [15:0] h;
    h = m[15:0];
    if (s == 2'h1) h = crc(m);
    if (s == 2'h2) h = m[47:32] ^ m[31:16] ^ m[15:0];
    return h[9:0];
  endfunction
  function automatic logic [47:0] rmac();
    logic [47:0] m;
    m = {$random(seed), $random(seed)};
    m[40] = 1'b0;
    return m;
  endfunction
  function automatic logic [6:0] pb_of(input int p);
    return 7'(1 << p);
  endfunction
  function automatic maclue_frame_t mk(input logic [47:0] da, input logic [47:0] sa, input int p);
    maclue_frame_t f;
    f = '0;
    f.da = da;
    f.sa = sa;
    f.src_port = 3'(p);
    f.len = MIN_FRAME;
    f.fid_member = 1'b1;
    return f;
  endfunction
  function automatic maclue_entry_t me(input logic [47:0] m, input logic [6:0] p);
    maclue_entry_t e;
    e = '0;
    e.valid = 1'b1;
    e.stat = 1'b1;
    e.mac = m;
    e.ports = p;
    return e;
  endfunction

  task automatic chk(input logic [9:0] exp, input logic [9:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic run(input maclue_frame_t f, input logic [6:0] e1, input logic [6:0] e2);
    maclue_rx_model_i.send(f);
    #1;
    chk(10'h001, {9'h000, res_v});
    chk({3'h0, e1}, {3'h0, m1});
    chk({3'h0, e2}, {3'h0, m2});
  endtask
  task automatic sw(input maclue_sw_t s, input int i, input int w, input maclue_entry_t e);
    @(posedge MCLK_I);
    sw_wr <= 1'b1;
    sw_sel <= s;
    sw_idx <= 10'(i);
    sw_way <= 2'(w);
    sw_entry <= e;
    @(posedge MCLK_I);
    sw_wr <= 1'b0;
  endtask
  task automatic results;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #(20 * 20000);
    n_fail++;
    results();
  end

  initial begin
    logic [47:0] a, b, c, d, x;
    int pa, pb;
    maclue_frame_t f;
    logic [6:0] m;
    logic [9:0] id;
    maclue_entry_t e;
    logic [6:0] fd;
    repeat (20) @(posedge MCLK_I);
    chk(10'h000, {3'h0, m2});
    RESET_I <= 1'b0;
    a = rmac();
    b = rmac();
    c = rmac();
    d = rmac();
    pa = $unsigned($random(seed)) % 7;
    pb = (pa + 3) % 7;
    run(mk(b, a, pa), 7'h7F, 7'h7F & ~pb_of(pa));
    run(mk(a, b, pb), pb_of(pa), pb_of(pa));
    run(mk(a, c, pa), pb_of(pa), 7'h00);
    f = mk(a, d, pb);
    f.frame_err = 1'b1;
    run(f, pb_of(pa), 7'h00);
    x = d;
    x[40] = 1'b1;
    run(mk(a, x, pb), pb_of(pa), pb_of(pa));
    run(mk(d, b, pb), 7'h7F, 7'h7F & ~pb_of(pb));
    run(mk(x, b, pb), 7'h7F, 7'h7F & ~pb_of(pb));
    for (int i = 0; i < 7; i++) begin
      long_frame <= (i >= 4);
      f = mk(a, b, pb);
      f.len = 11'(lens[i]);
      m = (lens[i] >= 64 && lens[i] <= ((i >= 4) ? 2000 : 1518)) ? pb_of(pa) : 7'h00;
      run(f, pb_of(pa), m);
    end
    long_frame <= 1'b0;
    f = mk(a, b, pb);
    f.pause = 1'b1;
    run(f, pb_of(pa), 7'h00);
    f.pause = 1'b0;
    f.mgmt = 1'b1;
    run(f, pb_of(pa), 7'h00);
    run(mk(c, a, pb), pb_of(pa), pb_of(pa));
    run(mk(a, c, pa), pb_of(pb), pb_of(pb));
    allow[pa] <= 7'h7F & ~pb_of(pb);
    run(mk(a, c, pa), pb_of(pb), 7'h00);
    allow[pa] <= 7'h7F;
    f = mk(a, c, pa);
    f.acl_override = 1'b1;
    f.acl_mask = 7'($random(seed));
    run(f, pb_of(pb), f.acl_mask);
    sw(MACLUE_SW_STAT, 3, 0, me(a, 7'h55));
    run(mk(a, c, pa), 7'h55, 7'h55 & ~pb_of(pa));
    run(mk(48'h0180C2000001, c, pa), 7'h7F, 7'h7F & ~pb_of(pa));
    rsv_en <= 1'b1;
    repeat (2) @(posedge MCLK_I);
    for (int i = 0; i < 8; i++) begin
      run(mk({40'h0180C20000, sfx[i]}, c, pa), rsv_exp[i], rsv_exp[i] & ~pb_of(pa));
    end
    sw(MACLUE_SW_RSV, 1, 0, me(48'h0, 7'h2A));
    run(mk(48'h0180C2000001, c, pa), 7'h2A, 7'h2A & ~pb_of(pa));
    // stale dynamic entry preloaded: stamp one full period behind the zero clock
    age_en <= 1'b0;
    e = me(d, pb_of(pb));
    e.stat = 1'b0;
    e.ts = 12'h000 - AGE_DEF_SEC;
    sw(MACLUE_SW_ALU, idx_of(2'h1, d), 3, e);
    repeat (1100) @(posedge MCLK_I);
    run(mk(d, c, pa), pb_of(pb), pb_of(pb));
    age_en <= 1'b1;
    repeat (1100) @(posedge MCLK_I);
    run(mk(d, c, pa), 7'h7F, 7'h7F & ~pb_of(pa));
    vlan_en <= 1'b1;
    x = rmac();
    f = mk(b, x, pa);
    f.fid_member = 1'b0;
    run(f, pb_of(pb), pb_of(pb));
    run(mk(x, c, pb), 7'h7F, 7'h7F & ~pb_of(pb));
    f = mk(b, x, pa);
    f.filter_group_id = 7'h05;
    run(f, 7'h7F, 7'h7F & ~pb_of(pa));
    f = mk(x, c, pb);
    f.filter_group_id = 7'h05;
    run(f, pb_of(pa), pb_of(pa));
    for (int s = 0; s < 4; s++) begin
      hash_sel <= 2'(s);
      vlan_en <= (s != 0);
      x = rmac();
      fd = 7'($random(seed));
      id = idx_of(2'(s), x) + ((s != 0) ? {3'h0, fd} : 10'h000);
      for (int w = 0; w < 4; w++) sw(MACLUE_SW_ALU, id, w, me(rmac(), 7'h01));
      f = mk(a, x, pb);
      f.filter_group_id = fd;
      run(f, 7'h55, 7'h55 & ~pb_of(pb));
      chk(10'h001, {9'h000, lfail});
      chk(id, lidx);
    end
    results();
  end
endmodule
